// File: design/cotp_defs.vh
// Register offsets, field positions, reset values and timing for the
// calibration / nonvolatile / waveform RAM register bank.
// Assumes an 8-bit register address and 8-bit data from the serial front end.
`ifndef COTP_DEFS_VH
`define COTP_DEFS_VH

// Register offsets
`define COTP_OFF_CAL_NVM        8'h1e
`define COTP_OFF_SUPPLY         8'h21
`define COTP_OFF_PERIOD         8'h22
`define COTP_OFF_PTR_HIGH       8'hfd
`define COTP_OFF_PTR_LOW        8'hfe
`define COTP_OFF_RAM_DATA       8'hff

// Calibration and nonvolatile control fields
`define COTP_CAL_TIME_HI        5
`define COTP_CAL_TIME_LO        4
`define COTP_NVM_STATUS_BIT     2
`define COTP_NVM_LAUNCH_BIT     0
`define COTP_CAL_TIME_RST       2'h2

// Nonvolatile image: configuration registers copied on launch
`define COTP_NVM_FIRST          8'h16
`define COTP_NVM_LAST           8'h1a
`define COTP_NVM_LEN            3'h5

// Calibration window minimum and maximum, in ms, per code
`define COTP_CAL_MIN_MS0        150
`define COTP_CAL_MIN_MS1        250
`define COTP_CAL_MIN_MS2        500
`define COTP_CAL_MIN_MS3        1000
`define COTP_CAL_MAX_MS0        350
`define COTP_CAL_MAX_MS1        450
`define COTP_CAL_MAX_MS2        700
`define COTP_CAL_MAX_MS3        1200

// Measurement scales: supply is code*5.6V/255, period step 98.46 us
`define COTP_SUPPLY_FULL_MV     5600
`define COTP_SUPPLY_CODES       255
`define COTP_PERIOD_STEP_NS     98460

// Reset values
`define COTP_RST_BYTE           8'h00

// FIFO geometry for the RAM write path
`define COTP_FIFO_WIDTH         24
`define COTP_FIFO_DEPTH         8
`define COTP_FIFO_AW            3

`endif

// File: design/cotp_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module cotp_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             srst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    ////////////////////////////////////////////////////////////////////////
    // Honest flags: full when count reaches depth, empty when zero
    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_q];

    // Storage has no reset; only pointers and count need a defined state
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and occupancy
    always @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// File: design/cotp_regs.v
// Register bank for calibration time, nonvolatile image control, live
// measurement readback and the indirect waveform RAM write port.
// Assumes a serial front end presents one-cycle byte write and read strobes
// with an 8-bit register offset, all synchronous to sys_clk.
//
// Functional notes
// - Two-bit calibration time, reset code two
// - Nonvolatile status bit two, set once programmed
// - Launch bit copies registers 0x16..0x1a out
// - Nonvolatile programming happens only once ever; srst clears the status bit, so after reset only the strap blocks a second copy
// - Supply code captured only while driving
// - Period code updated only while driving
// - RAM writes start at high:low pointer
// - Each data byte accepted while the FIFO has room is stored, pointer increments
`timescale 1ns/100ps
`default_nettype none
`include "cotp_defs.vh"

module cotp_regs (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        reg_wr_ready,
    input  wire        nvm_already_programmed,
    input  wire [7:0]  cfg_image_byte,
    output reg  [2:0]  cfg_image_index,
    output reg         nvm_prog_valid,
    output reg  [7:0]  nvm_prog_addr,
    output reg  [7:0]  nvm_prog_data,
    input  wire        nvm_prog_ready,
    output wire        nvm_busy,
    output wire [1:0]  cal_time_code,
    input  wire        wave_active,
    input  wire [7:0]  supply_sample,
    input  wire [7:0]  resonator_period_sample,
    output wire        wave_mem_wr,
    output wire [15:0] wave_mem_addr,
    output wire [7:0]  wave_mem_data,
    input  wire        wave_mem_ready
);

    // Nonvolatile sequencer states, one-hot
    localparam [2:0] NV_IDLE = 3'b001;
    localparam [2:0] NV_COPY = 3'b010;
    localparam [2:0] NV_DONE = 3'b100;

    reg [1:0]  cal_time_q;
    reg        nvm_status_q;
    reg        nvm_seen_q;
    reg [2:0]  nv_state_q;
    reg [2:0]  nv_state_d;
    reg [7:0]  supply_level_q;
    reg [7:0]  resonator_period_code_q;
    reg [7:0]  wave_mem_ptr_high_q;
    reg [7:0]  wave_mem_ptr_low_q;
    reg [7:0]  ram_data_q;
    wire       wr_ctl;
    wire       wr_data;
    wire       fifo_in_ready;
    wire [23:0] fifo_out;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    assign wr_ctl        = reg_wr & (reg_addr == `COTP_OFF_CAL_NVM);
    assign wr_data       = reg_wr & (reg_addr == `COTP_OFF_RAM_DATA);
    assign cal_time_code = cal_time_q;
    assign nvm_busy      = nv_state_q[1];
    // Ready drops whenever the FIFO is full, whatever the offset; only a data byte is refused, other registers are always accepted
    assign reg_wr_ready  = fifo_in_ready;

    always @(posedge sys_clk) begin
        if (srst) begin
            cal_time_q <= `COTP_CAL_TIME_RST;
        end else if (wr_ctl) begin
            cal_time_q <= reg_wdata[`COTP_CAL_TIME_HI:`COTP_CAL_TIME_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Nonvolatile sequencer: walks the five image bytes out to the memory
    always @* begin
        case (nv_state_q)
            NV_IDLE: begin
                // launch refused once programmed
                // The strap is honoured in its own cycle too, before status catches it
                if (wr_ctl && reg_wdata[`COTP_NVM_LAUNCH_BIT] && !nvm_status_q
                        && !(!nvm_seen_q && nvm_already_programmed)) begin
                    nv_state_d = NV_COPY;
                end else begin
                    nv_state_d = NV_IDLE;
                end
            end
            NV_COPY: begin
                if (nvm_prog_valid && nvm_prog_ready
                        && cfg_image_index == `COTP_NVM_LEN - 3'h1) begin
                    nv_state_d = NV_DONE;
                end else begin
                    nv_state_d = NV_COPY;
                end
            end
            NV_DONE: begin
                nv_state_d = NV_IDLE;
            end
            default: begin
                nv_state_d = NV_IDLE;
            end
        endcase
    end

    // copy registers 0x16..0x1a
    // Each byte is loaded from the index before it is offered, so address
    // and data never lag the index; costs one idle cycle per byte
    always @(posedge sys_clk) begin
        if (srst) begin
            nv_state_q      <= NV_IDLE;
            cfg_image_index <= 3'h0;
            nvm_prog_valid  <= 1'b0;
            nvm_prog_addr   <= `COTP_RST_BYTE;
            nvm_prog_data   <= `COTP_RST_BYTE;
        end else begin
            nv_state_q <= nv_state_d;
            if (nv_state_q != NV_COPY) begin
                cfg_image_index <= 3'h0;
                nvm_prog_valid  <= 1'b0;
            end else if (!nvm_prog_valid) begin
                nvm_prog_addr  <= `COTP_NVM_FIRST + {5'h00, cfg_image_index};
                nvm_prog_data  <= cfg_image_byte;
                nvm_prog_valid <= 1'b1;
            end else if (nvm_prog_ready) begin
                cfg_image_index <= cfg_image_index + 3'h1;
                nvm_prog_valid  <= 1'b0;
            end
        end
    end

    // status bit sticky, strap caught after reset release
    always @(posedge sys_clk) begin
        if (srst) begin
            nvm_status_q <= 1'b0;
            nvm_seen_q   <= 1'b0;
        end else begin
            nvm_seen_q <= 1'b1;
            if (!nvm_seen_q && nvm_already_programmed) begin
                nvm_status_q <= 1'b1;
            end else if (nv_state_q == NV_DONE) begin
                nvm_status_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // supply capture while driving
    always @(posedge sys_clk) begin
        if (srst) begin
            supply_level_q          <= `COTP_RST_BYTE;
            resonator_period_code_q <= `COTP_RST_BYTE;
        end else if (wave_active) begin
            supply_level_q          <= supply_sample;
            resonator_period_code_q <= resonator_period_sample;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer registers written by host
    always @(posedge sys_clk) begin
        if (srst) begin
            wave_mem_ptr_high_q <= `COTP_RST_BYTE;
            wave_mem_ptr_low_q  <= `COTP_RST_BYTE;
            ram_data_q          <= `COTP_RST_BYTE;
        end else if (wr_data && fifo_in_ready) begin
            {wave_mem_ptr_high_q, wave_mem_ptr_low_q} <=
                {wave_mem_ptr_high_q, wave_mem_ptr_low_q} + 16'h0001;
            ram_data_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `COTP_OFF_PTR_HIGH) begin
            wave_mem_ptr_high_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `COTP_OFF_PTR_LOW) begin
            wave_mem_ptr_low_q <= reg_wdata;
        end
    end

    // Buffer decouples host byte rate from the RAM's write acceptance
    cotp_fifo #(
        .WIDTH (`COTP_FIFO_WIDTH),
        .DEPTH (`COTP_FIFO_DEPTH),
        .AW    (`COTP_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_valid  (wr_data),
        .in_ready  (fifo_in_ready),
        .in_data   ({wave_mem_ptr_high_q, wave_mem_ptr_low_q, reg_wdata}),
        .out_valid (wave_mem_wr),
        .out_ready (wave_mem_ready),
        .out_data  (fifo_out)
    );

    assign wave_mem_addr = fifo_out[23:8];
    assign wave_mem_data = fifo_out[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Read data registered one cycle after the strobe
    // reserved bits read zero
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= `COTP_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `COTP_OFF_CAL_NVM: reg_rdata <= {2'b00, cal_time_q, 1'b0, nvm_status_q, 2'b00};
                `COTP_OFF_SUPPLY:  reg_rdata <= supply_level_q;
                `COTP_OFF_PERIOD:  reg_rdata <= resonator_period_code_q;
                `COTP_OFF_PTR_HIGH: reg_rdata <= wave_mem_ptr_high_q;
                `COTP_OFF_PTR_LOW: reg_rdata <= wave_mem_ptr_low_q;
                `COTP_OFF_RAM_DATA: reg_rdata <= ram_data_q;
                default:           reg_rdata <= `COTP_RST_BYTE;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: tb/cotp_regs_asserts.sv
// Checker for the register bank, watching only the bank's own ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cotp_regs_chk (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_wr_ready,
    input wire logic        nvm_already_programmed,
    input wire logic        nvm_prog_valid,
    input wire logic [7:0]  nvm_prog_addr,
    input wire logic        nvm_prog_ready,
    input wire logic        nvm_busy,
    input wire logic [1:0]  cal_time_code,
    input wire logic        wave_mem_wr,
    input wire logic [7:0]  wave_mem_data,
    input wire logic        wave_mem_ready
);
    logic first_q;
    logic done_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    // Image counts as programmed after the strap or a finished copy
    always_ff @(posedge sys_clk) begin
        first_q <= srst;
        done_q <= srst ? 1'b0 : done_q | $fell(nvm_busy) | (first_q & nvm_already_programmed);
    end
    sequence s_launch;
        reg_wr && reg_addr == 8'h1e && reg_wdata[0] && !nvm_busy && !$past(nvm_busy)
            && !done_q && !first_q;
    endsequence
    sequence s_ram_first;
        reg_wr && reg_wr_ready && reg_addr == 8'hff && !wave_mem_wr;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_cal_reset: assert property ($fell(srst) |-> cal_time_code == 2'h2)
        else $error("calibration code not two after reset");
    chk_cal_write: assert property (reg_wr && reg_addr == 8'h1e |=>
        cal_time_code == $past(reg_wdata[5:4])) else $error("calibration code not written");
    chk_launch_start: assert property (s_launch |=> nvm_busy)
        else $error("launch did not start copy");
    chk_one_shot: assert property (done_q |-> !$rose(nvm_busy))
        else $error("copy started a second time");
    chk_prog_addr: assert property (nvm_prog_valid && nvm_prog_ready |-> nvm_busy
        && nvm_prog_addr >= 8'h16 && nvm_prog_addr <= 8'h1a) else $error("bad image address");
    chk_ram_first: assert property (s_ram_first |=> wave_mem_wr
        && wave_mem_data == $past(reg_wdata)) else $error("RAM byte not forwarded");
    chk_ram_hold: assert property (wave_mem_wr && !wave_mem_ready |=> wave_mem_wr
        && $stable(wave_mem_data)) else $error("RAM request dropped while stalled");
    chk_rsvd_zero: assert property (reg_rd && reg_addr == 8'h1e |=>
        (reg_rdata & 8'hcb) == 8'h00) else $error("reserved control bits not zero");
    chk_status_flag: assert property (reg_rd && reg_addr == 8'h1e && !nvm_busy |=>
        reg_rdata[2] == $past(done_q)) else $error("status flag wrong");
endmodule
bind cotp_regs cotp_regs_chk u_chk (.*);
`default_nettype wire

// File: tb/cotp_mem_model.sv
// Waveform RAM and nonvolatile memory seen from the bank's far side.
// Assumes the bench raises stall to make both memories slow.
`timescale 1ns/100ps
`default_nettype none
module cotp_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        stall,
    input  wire logic        wave_mem_wr,
    input  wire logic [15:0] wave_mem_addr,
    input  wire logic [7:0]  wave_mem_data,
    output logic             wave_mem_ready,
    input  wire logic        nvm_prog_valid,
    input  wire logic [7:0]  nvm_prog_addr,
    input  wire logic [7:0]  nvm_prog_data,
    output logic             nvm_prog_ready,
    input  wire logic [2:0]  cfg_image_index,
    output logic [7:0]       cfg_image_byte
);
    logic [7:0] ram [0:65535];
    logic [7:0] nvm [0:255];
    int         nvm_cnt = 0;
    // Stall holds both memories off so the bank must queue and wait
    assign wave_mem_ready = !stall;
    assign nvm_prog_ready = !stall;
    // Image pattern is arbitrary but differs per byte
    assign cfg_image_byte = 8'hc0 ^ {5'h00, cfg_image_index};
    // Each accepted byte lands at the address given with it
    always @(posedge sys_clk) begin
        if (wave_mem_wr && wave_mem_ready)
            ram[wave_mem_addr] <= wave_mem_data;
        if (nvm_prog_valid && nvm_prog_ready) begin
            nvm[nvm_prog_addr] <= nvm_prog_data;
            nvm_cnt <= nvm_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_calib_otp_waveform_ram_regs.sv
// Self-checking bench for the register bank and its memory model.
// Assumes the bank's ports are named as the signals below.
`timescale 1ns/100ps
`default_nettype none
module test_calib_otp_waveform_ram_regs;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        nvm_already_programmed = 1'b0;
    logic        wave_active = 1'b0;
    logic [7:0]  supply_sample = 8'h00;
    logic [7:0]  resonator_period_sample = 8'h00;
    logic        stall = 1'b0;
    logic [7:0]  reg_rdata, cfg_image_byte, nvm_prog_addr, nvm_prog_data, wave_mem_data;
    logic [2:0]  cfg_image_index;
    logic [1:0]  cal_time_code;
    logic [15:0] wave_mem_addr;
    logic        reg_wr_ready, nvm_prog_valid, nvm_prog_ready, nvm_busy, wave_mem_wr;
    logic        wave_mem_ready;
    int          failures = 0;
    int          num_checks = 0;
    cotp_regs uut (.*);
    cotp_mem_model mdl (.*);
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge sys_clk);
        srst <= 1'b1;
        nvm_already_programmed <= strap;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // Bounded wait for copy and RAM queue to go quiet
    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while ((nvm_busy !== 1'b0 || wave_mem_wr !== 1'b0) && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 300) begin
            failures++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        rd(8'h1e, 8'h20);
        for (int i = 0; i < 4; i++) rd(i < 2 ? 8'h21 + i[7:0] : 8'hfb + i[7:0], 8'h00);
        $display("reset values done");
        // host ends on the longest window
        for (int i = 0; i < 4; i++) begin
            wr(8'h1e, 8'hce | (i[7:0] << 4));
            rd(8'h1e, i[7:0] << 4);
            chk(16'(cal_time_code), 16'(i));
        end
        $display("calibration codes done");
        @(posedge sys_clk);
        supply_sample <= 8'h5a;
        resonator_period_sample <= 8'h3c;
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h00);
        @(posedge sys_clk);
        wave_active <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wave_active <= 1'b0;
        supply_sample <= 8'ha5;
        resonator_period_sample <= 8'hc3;
        wr(8'h21, 8'hff);
        rd(8'h21, 8'h5a);
        rd(8'h22, 8'h3c);
        $display("measurements done");
        // Stalled RAM: eight bytes queue, the rest are refused
        @(posedge sys_clk);
        stall <= 1'b1;
        wr(8'hfd, 8'hff);
        wr(8'hfe, 8'hfe);
        for (int i = 0; i < 10; i++) wr(8'hff, 8'h40 + i[7:0]);
        chk(16'(reg_wr_ready), 16'h0000);
        stall <= 1'b0;
        wait_idle();
        for (int i = 0; i < 8; i++) chk(16'(mdl.ram[16'(16'hfffe + i)]), 16'(8'h40 + i));
        rd(8'hfd, 8'h00);
        rd(8'hfe, 8'h06);
        $display("RAM port done");
        wr(8'h1e, 8'h31);
        // Slow memory for a while: the copy must hold its byte, not skip it
        stall <= 1'b1;
        repeat (3) @(posedge sys_clk);
        stall <= 1'b0;
        wait_idle();
        for (int i = 0; i < 5; i++) chk(16'(mdl.nvm[8'h16 + i]), 16'(8'hc0 ^ i));
        rd(8'h1e, 8'h34);
        wr(8'h1e, 8'h31);
        wait_idle();
        chk(16'(mdl.nvm_cnt), 16'h0005);
        $display("image copy done");
        do_reset(1'b1);
        rd(8'h1e, 8'h24);
        $display("strap done");
        give_verdict();
    end
endmodule
`default_nettype wire
